// File: design/mef_defines.vh
`ifndef MEF_DEFINES_VH
`define MEF_DEFINES_VH

// ====================================================================
// Primary header fields
`define MEF_VERSION 3'h0
`define MEF_TYPE_BIT 1'h0
`define MEF_DFH_FLAG 1'h1
`define MEF_APID 7'h47
`define MEF_CATEGORY 4'h7
`define MEF_SEG_FLAGS 2'h3
`define MEF_SEQ_W 14
`define MEF_SEQ_RESET 14'h0000
`define MEF_LEN_OFFSET 16'h0009
`define MEF_SRC_BYTES 16'h0002

// ====================================================================
// Secondary header fields
`define MEF_SVC_VERSION 3'h2
`define MEF_CHECKSUM_FLAG 1'h0
`define MEF_SPARE_BITS 4'h0
`define MEF_PKT_TYPE 8'h05
`define MEF_SUBTYPE_WARN 8'h02
`define MEF_SUBTYPE_GROUND 8'h03
`define MEF_PAD_BYTE 8'h00

// ====================================================================
// Event codes and packet geometry
`define MEF_CODE_RECOVERED 16'ha7fb
`define MEF_CODE_LOST 16'ha7fc
`define MEF_PKT_BYTES 5'h12
`define MEF_LAST_IDX 5'h11
`define MEF_FIFO_WIDTH 9
`define MEF_FIFO_DEPTH 32

`endif

// File: design/mef_fifo.v
`timescale 1ns/1ps
// ====================================================================
// Synchronous FIFO with valid and ready on both sides.
module mef_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Fill side
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // Drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_ptr_q;
  reg [AW:0] rd_ptr_q;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;
  integer i;

  // The extra pointer bit tells a full FIFO from an empty one.
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign do_wr = in_valid_i & ~full;
  assign do_rd = out_ready_i & ~empty;
  assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];

  // Storage is cleared at reset so the read port never shows unknowns.
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
      begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end
    else
    begin
      if (do_wr)
      begin
        mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule // mef_fifo

// File: design/mef_framer.v
`timescale 1ns/1ps
`include "mef_defines.vh"
// ====================================================================
// Mirror error event packet framer.
// Each failure event that is not dropped becomes one 18-byte telemetry packet, sent as a
// byte stream through a 32-word FIFO to the data-handling receiver.
// Packets are never interleaved: one is built whole before the next.
module mef_framer #(
  parameter SEQ_W = `MEF_SEQ_W
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Failure events from the mirror controller, one-cycle pulses
  input wire space_recovered_report_i,
  input wire space_lost_report_i,
  // Acquisition time base, seconds and fractional seconds
  input wire [31:0] time_coarse_i,
  input wire [15:0] time_fine_i,
  // Byte stream towards the receiver
  output wire [7:0] tx_data_o,
  output wire tx_last_o,
  output wire tx_valid_o,
  input wire tx_ready_i,
  // Status
  output wire busy_o,
  output reg pkt_done_o,
  output reg event_dropped_o,
  output wire [SEQ_W-1:0] seq_count_o
);

  // ==================================================================
  // State encoding
  localparam ST_IDLE = 2'h0;
  localparam ST_SEND = 2'h1;
  localparam ST_DONE = 2'h2;
  // IDLE waits for a pending slot, SEND pushes one byte per accepted
  // cycle, and DONE spends one cycle closing the packet.

  // Framing state and byte index.
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [4:0] idx_q;
  reg [4:0] idx_d;
  // Stream sequence counter.
  reg [SEQ_W-1:0] seq_count_q;
  // Pending slots, one per report kind, each with its captured time.
  reg pend_rec_q;
  reg pend_lost_q;
  reg [47:0] time_rec_q;
  reg [47:0] time_lost_q;
  // Fields frozen for the packet being sent.
  reg [47:0] pkt_time_q;
  reg pkt_lost_q;
  reg [SEQ_W-1:0] pkt_seq_q;
  // Buffer and selection nets.
  wire fifo_in_ready;
  wire [8:0] fifo_out;
  wire load_rec;
  wire load_lost;
  wire push;
  wire [7:0] cur_byte;
  wire cur_last;

  // ==================================================================
  // Packet byte generator.
  // Byte index 0 is sent first; within each byte the top bit leads,
  // so the whole packet leaves most significant bit first.
  // Byte map of one packet, index first:
  //   00-01  version, type, header flag, application id, category.
  //   02-03  segmentation flags and the 14-bit sequence count.
  //   04-05  packet length, source data bytes plus nine.
  //   06-09  whole seconds of the acquisition time.
  //   0a-0b  fractional seconds of the acquisition time.
  //   0c     service version, checksum flag and spare bits.
  //   0d     packet type.
  //   0e     packet subtype, warning or ground action.
  //   0f     pad byte.
  //   10-11  event code, the whole source data field.
  // The receiver finds the end from the length field alone, so the
  // byte count here and the length value must always move together.
  // Every field is rebuilt from the frozen packet registers, so a new
  // event cannot disturb a packet that is already under way.
  function [7:0] pkt_byte;
    input [4:0] idx;
    input [SEQ_W-1:0] seq;
    input [47:0] stamp;
    input lost;
    reg [15:0] id_word;
    reg [15:0] seq_word;
    reg [15:0] len_word;
    reg [15:0] code_word;
    reg [7:0] svc_byte;
    begin
      id_word = {`MEF_VERSION, `MEF_TYPE_BIT, `MEF_DFH_FLAG,
                 `MEF_APID, `MEF_CATEGORY};
      seq_word = {`MEF_SEG_FLAGS, seq[13:0]};
      len_word = `MEF_SRC_BYTES + `MEF_LEN_OFFSET;
      svc_byte = {`MEF_SVC_VERSION, `MEF_CHECKSUM_FLAG, `MEF_SPARE_BITS};
      code_word = lost ? `MEF_CODE_LOST : `MEF_CODE_RECOVERED;
      case (idx)
        5'h00: pkt_byte = id_word[15:8];
        5'h01: pkt_byte = id_word[7:0];
        5'h02: pkt_byte = seq_word[15:8];
        5'h03: pkt_byte = seq_word[7:0];
        5'h04: pkt_byte = len_word[15:8];
        5'h05: pkt_byte = len_word[7:0];
        // Four bytes of whole seconds, then two of fraction.
        5'h06: pkt_byte = stamp[47:40];
        5'h07: pkt_byte = stamp[39:32];
        5'h08: pkt_byte = stamp[31:24];
        5'h09: pkt_byte = stamp[23:16];
        5'h0a: pkt_byte = stamp[15:8];
        5'h0b: pkt_byte = stamp[7:0];
        5'h0c: pkt_byte = svc_byte;
        5'h0d: pkt_byte = `MEF_PKT_TYPE;
        5'h0e: pkt_byte = lost ? `MEF_SUBTYPE_GROUND : `MEF_SUBTYPE_WARN;
        5'h0f: pkt_byte = `MEF_PAD_BYTE;
        // Source data is the event code and nothing more.
        5'h10: pkt_byte = code_word[15:8];
        5'h11: pkt_byte = code_word[7:0];
        default: pkt_byte = 8'h00;
      endcase
    end
  endfunction

  // ==================================================================
  // Packet selection.
  // A new packet is loaded only from idle; the recovered report goes
  // first when both are waiting, as its failure sequence ended earlier.
  assign load_rec = (state_q == ST_IDLE) & pend_rec_q;
  assign load_lost = (state_q == ST_IDLE) & ~pend_rec_q & pend_lost_q;

  // Bytes are pushed only while the FIFO accepts, so a stalled receiver
  // freezes the framer rather than losing part of a packet.
  assign push = (state_q == ST_SEND) & fifo_in_ready;
  assign cur_byte = pkt_byte(idx_q, pkt_seq_q, pkt_time_q, pkt_lost_q);
  assign cur_last = (idx_q == `MEF_LAST_IDX);

  // ==================================================================
  // Pending event slots.
  // Time is captured in the cycle the event arrives, which marks the
  // start of acquisition, not when the packet is later sent. A fresh
  // event in the cycle its slot is emptied refills the slot, so the set
  // wins. A second event of the same kind while one already waits has
  // no slot and is reported on event_dropped_o.
  // A limitation: only one event of each kind can wait, so a burst of
  // one kind faster than a packet time loses events; the drop pulse
  // lets the controller count them.
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pend_rec_q <= 1'b0;
      pend_lost_q <= 1'b0;
      time_rec_q <= 48'h000000000000;
      time_lost_q <= 48'h000000000000;
      event_dropped_o <= 1'b0;
    end
    else
    begin
      event_dropped_o <= (space_recovered_report_i & pend_rec_q & ~load_rec) |
                         (space_lost_report_i & pend_lost_q & ~load_lost);
      if (space_recovered_report_i & (~pend_rec_q | load_rec))
      begin
        pend_rec_q <= 1'b1;
        time_rec_q <= {time_coarse_i, time_fine_i};
      end
      else if (load_rec)
      begin
        pend_rec_q <= 1'b0;
      end
      if (space_lost_report_i & (~pend_lost_q | load_lost))
      begin
        pend_lost_q <= 1'b1;
        time_lost_q <= {time_coarse_i, time_fine_i};
      end
      else if (load_lost)
      begin
        pend_lost_q <= 1'b0;
      end
    end
  end

  // ==================================================================
  // Packet registers and the stream's sequence counter.
  // Both reports share one application id and category, hence one
  // counter; it wraps at 14 bits like the field it fills.
  // It advances at load, not at the event, so a dropped event never
  // leaves a hole in the sequence that the receiver tracks.
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      seq_count_q <= `MEF_SEQ_RESET;
      pkt_seq_q <= `MEF_SEQ_RESET;
      pkt_time_q <= 48'h000000000000;
      pkt_lost_q <= 1'b0;
    end
    else if (load_rec | load_lost)
    begin
      pkt_seq_q <= seq_count_q;
      seq_count_q <= seq_count_q + 1'b1;
      pkt_lost_q <= load_lost;
      pkt_time_q <= load_lost ? time_lost_q : time_rec_q;
    end
  end

  // ==================================================================
  // Framing state machine, next-state logic.
  // The DONE cycle costs one slot between packets; it keeps the index
  // reset out of the push path and gives the done pulse a clean cycle.
  always @*
  begin
    state_d = state_q;
    idx_d = idx_q;
    case (state_q)
      ST_IDLE:
      begin
        if (load_rec | load_lost)
        begin
          state_d = ST_SEND;
          idx_d = 5'h00;
        end
      end
      ST_SEND:
      begin
        if (push)
        begin
          if (cur_last)
          begin
            state_d = ST_DONE;
          end
          else
          begin
            idx_d = idx_q + 1'b1;
          end
        end
      end
      ST_DONE:
      begin
        state_d = ST_IDLE;
        idx_d = 5'h00;
      end
      default:
      begin
        state_d = ST_IDLE;
        idx_d = 5'h00;
      end
    endcase
  end

  // Framing state machine, state registers and done pulse.
  // The done pulse marks the last byte entering the buffer, not the
  // receiver taking it, so it may lead the stream by many cycles.
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_IDLE;
      idx_q <= 5'h00;
      pkt_done_o <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      pkt_done_o <= push & cur_last;
    end
  end

  // ==================================================================
  // Output buffer.
  // The last flag rides with each byte so the receiver can check its
  // length-based delimiting against the framer's own boundary.
  // Thirty-two words hold one packet and most of a second, so of two
  // reports raised together, the second is only partly built while the receiver stalls.
  // AW is the address width, the base-two logarithm of the depth.
  mef_fifo #(
    .WIDTH(`MEF_FIFO_WIDTH),
    .DEPTH(`MEF_FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_data_i({cur_last, cur_byte}),
    .in_valid_i(state_q == ST_SEND),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i)
  );

  // ==================================================================
  // Status and stream outputs.
  // Busy includes the pending slots, so a waiting event counts as work
  // in hand; seq_count_o shows the count the next packet will carry.
  assign tx_data_o = fifo_out[7:0];
  assign tx_last_o = fifo_out[8];
  assign busy_o = (state_q != ST_IDLE) | pend_rec_q | pend_lost_q;
  assign seq_count_o = seq_count_q;

endmodule // mef_framer

// File: dv/mef_framer_sva.sv
`timescale 1ns/1ps
// ==========
// Port checker for the framer.
module mef_framer_sva #(
  parameter SEQ_W = 14
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Events and time
  input wire space_recovered_report_i,
  input wire space_lost_report_i,
  input wire [31:0] time_coarse_i,
  input wire [15:0] time_fine_i,
  // Byte stream and status
  input wire [7:0] tx_data_o,
  input wire tx_last_o,
  input wire tx_valid_o,
  input wire tx_ready_i,
  input wire busy_o,
  input wire pkt_done_o,
  input wire event_dropped_o,
  input wire [SEQ_W-1:0] seq_count_o
);
  reg [4:0] pos_q;
  reg [7:0] sub_q;
  wire take = tx_valid_o && tx_ready_i;
  wire ev = space_recovered_report_i || space_lost_report_i;
  // Byte position in the packet; the last flag closes it.
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      pos_q <= 5'h00;
    else if (take)
      pos_q <= tx_last_o ? 5'h00 : pos_q + 5'h01;
  end
  // The subtype decides which event code must follow.
  always @(posedge clk_sys_i)
  begin
    if (take && pos_q == 5'h0e)
      sub_q <= tx_data_o;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_idle_ev;
    ev && !busy_o;
  endsequence
  sequence s_stall;
    tx_valid_o && !tx_ready_i;
  endsequence
  AST_BUSY: assert property (s_idle_ev |=> busy_o [*8])
    else $error("busy missing after event");
  AST_HOLD: assert property (s_stall |=> tx_valid_o && $stable({tx_data_o, tx_last_o}))
    else $error("byte changed while stalled");
  AST_SEQ: assert property ($changed(seq_count_o) |->
    seq_count_o == $past(seq_count_o) + 1'b1)
    else $error("sequence step wrong");
  AST_HDR: assert property (tx_valid_o && pos_q < 5'h02 |->
    tx_data_o == (pos_q[0] ? 8'h77 : 8'h0c))
    else $error("primary header wrong");
  AST_SEG: assert property (tx_valid_o && pos_q == 5'h02 |-> tx_data_o[7:6] == 2'h3)
    else $error("segmentation flags wrong");
  AST_LEN: assert property (tx_valid_o && pos_q == 5'h05 |-> tx_data_o == 8'h0b)
    else $error("length wrong");
  AST_TYPE: assert property (tx_valid_o && pos_q == 5'h0d |-> tx_data_o == 8'h05)
    else $error("packet type wrong");
  AST_PAD: assert property (tx_valid_o && pos_q == 5'h0f |-> tx_data_o == 8'h00)
    else $error("pad wrong");
  AST_CODE: assert property (tx_valid_o && pos_q == 5'h11 |->
    tx_data_o == (sub_q == 8'h02 ? 8'hfb : 8'hfc))
    else $error("event code wrong");
  AST_LAST: assert property (tx_valid_o |-> tx_last_o == (pos_q == 5'h11))
    else $error("last flag wrong");
  AST_DROP: assert property (event_dropped_o |-> $past(ev))
    else $error("drop without event");
  AST_DONE: assert property (pkt_done_o |-> busy_o ##1 !pkt_done_o)
    else $error("done pulse wrong");
endmodule // mef_framer_sva
bind mef_framer mef_framer_sva #(.SEQ_W(SEQ_W)) u_mef_framer_sva (.clk_sys_i(clk_sys_i),
  .reset_i(reset_i), .space_recovered_report_i(space_recovered_report_i),
  .space_lost_report_i(space_lost_report_i), .time_coarse_i(time_coarse_i),
  .time_fine_i(time_fine_i), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .busy_o(busy_o), .pkt_done_o(pkt_done_o),
  .event_dropped_o(event_dropped_o), .seq_count_o(seq_count_o));

// File: dv/mef_rx_model.sv
`timescale 1ns/1ps
// ==========
// Receiver: splits packets by the length field, watches sequence.
module mef_rx_model (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Byte stream from the framer
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output logic tx_ready_o,
  // Pacing: 0 prompt, 1 random stalls, 2 stalled
  input wire [1:0] mode_i
);
  logic [8:0] got[$];
  logic [7:0] pb;
  logic [15:0] len;
  logic [13:0] nxt;
  int idx;
  int gaps = 0;
  // Ready moves on the falling edge, away from the sampling edge.
  always @(negedge clk_sys_i)
    tx_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && $urandom % 2);
  // A byte counts only where valid and ready meet at a rising edge.
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      idx <= 0;
      nxt <= 14'h0000;
    end
    else if (tx_valid_i && tx_ready_o)
    begin
      if (idx == 3 && {pb[5:0], tx_data_i} !== nxt)
        gaps <= gaps + 1;
      if (idx == 3)
        nxt <= {pb[5:0], tx_data_i} + 14'h0001;
      if (idx == 5)
        len <= {pb, tx_data_i};
      got.push_back({idx > 5 && idx == len + 6, tx_data_i});
      idx <= (idx > 5 && idx == len + 6) ? 0 : idx + 1;
      pb <= tx_data_i;
    end
  end
endmodule // mef_rx_model

// File: dv/mirror_error_event_packet_framer_bench.sv
`timescale 1ns/1ps
module mirror_error_event_packet_framer_bench;
  // ==========
  // Stimulus and observation
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic space_recovered_report_i = 1'b0;
  logic space_lost_report_i = 1'b0;
  logic [31:0] time_coarse_i = 32'h0;
  logic [15:0] time_fine_i = 16'h0;
  logic [1:0] mode = 2'h0;
  wire [7:0] tx_data_o;
  wire tx_last_o, tx_valid_o, tx_ready_i, busy_o, pkt_done_o, event_dropped_o;
  wire [13:0] seq_count_o;
  logic [8:0] exp_q[$];
  logic [13:0] es = 14'h0000;
  logic [1:0] k;
  logic hit;
  int fail_count = 0;
  int compares = 0;
  int dones = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  // Time moves every cycle, so a late capture is caught.
  always @(negedge clk_sys_i)
  begin
    time_coarse_i <= $urandom;
    time_fine_i <= $urandom;
  end
  // Done pulses are counted away from the edge that launches them.
  always @(negedge clk_sys_i)
    if (pkt_done_o === 1'b1)
      dones <= dones + 1;
  mef_framer u_mef_framer (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .space_recovered_report_i(space_recovered_report_i),
    .space_lost_report_i(space_lost_report_i), .time_coarse_i(time_coarse_i),
    .time_fine_i(time_fine_i), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .busy_o(busy_o),
    .pkt_done_o(pkt_done_o), .event_dropped_o(event_dropped_o), .seq_count_o(seq_count_o));
  mef_rx_model u_mef_rx_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .mode_i(mode));
  // ==========
  // Expected byte i of a packet, with its end flag on top.
  function [8:0] bx(input [4:0] i, input [13:0] s, input [47:0] t, input l);
    case (i)
      5'h00: bx = 9'h00c;
      5'h01: bx = 9'h077;
      5'h02: bx = {3'h3, s[13:8]};
      5'h03: bx = {1'b0, s[7:0]};
      5'h04: bx = 9'h000;
      5'h05: bx = 9'h00b;
      5'h0c: bx = 9'h040;
      5'h0d: bx = 9'h005;
      5'h0e: bx = l ? 9'h003 : 9'h002;
      5'h0f: bx = 9'h000;
      5'h10: bx = 9'h0a7;
      5'h11: bx = l ? 9'h1fc : 9'h1fb;
      default: bx = {1'b0, t[8 * (11 - i) +: 8]};
    endcase
  endfunction
  task chk(input ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task put(input l);
    for (int i = 0; i < 18; i++)
      exp_q.push_back(bx(5'(i), es, {time_coarse_i, time_fine_i}, l));
    es = es + 14'h0001;
  endtask
  // One-cycle event pulse; the time stands from here through the edge.
  task ev(input r, input l, input keep);
    @(negedge clk_sys_i);
    space_recovered_report_i <= r;
    space_lost_report_i <= l;
    #1;
    if (keep && r)
      put(1'b0);
    if (keep && l)
      put(1'b1);
    @(negedge clk_sys_i);
    space_recovered_report_i <= 1'b0;
    space_lost_report_i <= 1'b0;
  endtask
  // Wait until idle and all bytes are in, then compare in order.
  task drain;
    int n;
    for (n = 0; n < 3000; n++)
    begin
      @(posedge clk_sys_i);
      #1;
      if (busy_o === 1'b0 && tx_valid_o === 1'b0 && u_mef_rx_model.got.size() >= exp_q.size())
        break;
    end
    if (n == 3000)
    begin
      chk(1'b0, "timeout");
      end_of_test;
    end
    while (exp_q.size() > 0)
      chk(u_mef_rx_model.got.pop_front() === exp_q.pop_front(), "packet byte");
    chk(u_mef_rx_model.got.size() == 0, "extra bytes");
  endtask
  // ==========
  // Main sequence
  initial
  begin
    void'($urandom(81201));
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i) reset_i <= 1'b0;
    ev(1'b1, 1'b0, 1'b1);
    drain;
    chk(seq_count_o === 14'h0001, "sequence count");
    ev(1'b0, 1'b1, 1'b1);
    drain;
    ev(1'b1, 1'b1, 1'b1);
    drain;
    ev(1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge clk_sys_i);
    ev(1'b1, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    hit = (event_dropped_o === 1'b1);
    @(posedge clk_sys_i);
    #1 hit = hit | (event_dropped_o === 1'b1);
    chk(hit, "drop pulse");
    drain;
    mode = 2'h2;
    ev(1'b1, 1'b1, 1'b1);
    repeat (80) @(posedge clk_sys_i);
    #1 chk(busy_o === 1'b1 && tx_valid_o === 1'b1, "full fifo stall");
    @(negedge clk_sys_i) mode <= 2'h1;
    drain;
    repeat (8)
    begin
      k = 2'(1 + $urandom % 3);
      ev(k[0], k[1], 1'b1);
      drain;
    end
    chk(u_mef_rx_model.gaps === 0, "sequence gap");
    chk(seq_count_o === es, "final count");
    chk(dones == es, "done pulses");
    end_of_test;
  end
endmodule // mirror_error_event_packet_framer_bench
